// *** include/mbx_pkg.sv ***
// Constants, field positions and carrier types for the dual-port mailbox RAM.
// Assumes one 40 MHz core clock; both host buses arrive asynchronously on pins.
package mbx_pkg;

    // ************************************************************
    // Sizes and timing
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int RAM_DEPTH = 256;
    localparam int NUM_PORTS = 2;
    localparam int NUM_REGS = 8;
    localparam real CLK_PERIOD_NS = 25.0;

    // ************************************************************
    // Register select codes, identical at both ports
    // ************************************************************
    typedef logic [2:0] mbx_sel_t;
    localparam mbx_sel_t SEL_RAM_ACCESS_AUTOINC = 3'h0;
    localparam mbx_sel_t SEL_RAM_ACCESS_PLAIN = 3'h1;
    localparam mbx_sel_t SEL_INCOMING_NOTE = 3'h2;
    localparam mbx_sel_t SEL_OUTGOING_NOTE = 3'h3;
    localparam mbx_sel_t SEL_PORT_CONFIGURATION = 3'h4;
    localparam mbx_sel_t SEL_OWN_RAM_POINTER = 3'h5;
    localparam mbx_sel_t SEL_PORT_CONDITION = 3'h6;
    localparam mbx_sel_t SEL_PEER_RAM_POINTER = 3'h7;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CFG_SOFT_LOCK_REQUEST = 0;
    localparam int COND_INCOMING_NOTE_FLAG = 0;
    localparam int COND_OUTGOING_FREE_FLAG = 1;
    localparam int COND_LOCK_ACKNOWLEDGE_FLAG = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] NOTE_RESET = 8'h00;
    localparam logic [7:0] IDLE_READ = 8'h00;
    localparam logic [7:0] LFSR_SEED = 8'h5a;
    localparam logic [7:0] LFSR_TAPS = 8'hb8;
    localparam logic [7:0] PTR_STEP = 8'h01;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic cs;
        logic we;
        logic oe;
        logic lock;
        mbx_sel_t sel;
        logic [7:0] data;
    } mbx_host_t;

    typedef enum {LOCK_NONE, LOCK_BY_A, LOCK_BY_B} mbx_lock_t;

endpackage

// *** hdl/mbx_top.sv ***
// Dual-port mailbox: two host register ports sharing a 256-byte RAM through pointers.
// Assumes host strobes, select lines, lock inputs and the wait sampling clock are asynchronous pins.
`timescale 1ns/1ps
module mbx_top (
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    input wire logic WAIT_SYNC_CLOCK_IN,
    input wire logic [1:0] HOST_CS_N_IN,
    input wire logic [1:0] HOST_WE_N_IN,
    input wire logic [1:0] HOST_OE_N_IN,
    input wire logic [1:0] HOST_LOCK_IN,
    input wire logic [1:0][2:0] REGISTER_SELECT_LINES_IN,
    input wire logic [1:0][7:0] HOST_DATA_IN,
    output logic [1:0][7:0] HOST_DATA_OUT,
    output logic [1:0] HOST_DATA_OE_OUT,
    output logic [1:0] HOST_READY_OUT,
    output logic [1:0] PORT_RAM_GRANT_OUT
);

    // ************************************************************
    // Storage and state
    // ************************************************************
    logic [7:0] ram [mbx_pkg::RAM_DEPTH];
    mbx_pkg::mbx_host_t raw [2];
    mbx_pkg::mbx_host_t sync1 [2];
    mbx_pkg::mbx_host_t sync2 [2];
    mbx_pkg::mbx_host_t sync3 [2];
    mbx_pkg::mbx_host_t host [2];
    mbx_pkg::mbx_host_t host_prev [2];
    logic [7:0] ptr [2];
    logic [7:0] next_ptr [2];
    logic [7:0] note [2];
    logic [7:0] cfg [2];
    logic [7:0] cond [2];
    logic [7:0] view [2][mbx_pkg::NUM_REGS];
    logic [7:0] read_value [2];
    logic [7:0] wr_data [2];
    logic [1:0] note_flag;
    logic [1:0] free_flag;
    logic [1:0] lock_ack;
    logic [1:0] grant;
    logic [1:0] next_grant;
    logic [1:0] req;
    logic [1:0] req_prev;
    logic [1:0] req_end;
    logic [1:0] can_win;
    logic [1:0] wr_commit;
    logic [1:0] rd_on;
    logic [1:0] rd_end;
    logic [1:0] lock_req;
    logic [1:0] ready;
    logic [1:0] grant_seen;
    // Per-port strobe decodes and lockout blocks
    logic [1:0] note_wr;
    logic [1:0] cfg_wr;
    logic [1:0] own_ptr_wr;
    logic [1:0] peer_ptr_wr;
    logic [1:0] note_taken;
    logic [1:0] inc_done;
    logic [1:0] ram_wr;
    logic [1:0] lock_mine;
    logic [1:0] lock_block;
    logic [7:0] ram_rd [2];
    logic [7:0] lfsr;
    logic wclk_s1;
    logic wclk_s2;
    logic wclk_s3;
    logic wclk;
    logic wclk_prev;
    logic wclk_rise;
    logic tie;
    mbx_pkg::mbx_lock_t lock_owner;
    mbx_pkg::mbx_lock_t next_lock_owner;

    // ************************************************************
    // Per-port synchronisers, decode and register views
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < mbx_pkg::NUM_PORTS; i++) begin : g_port
            localparam int O = 1 - i;

            assign raw[i].cs = ~HOST_CS_N_IN[i];
            assign raw[i].we = ~HOST_WE_N_IN[i];
            assign raw[i].oe = ~HOST_OE_N_IN[i];
            assign raw[i].lock = HOST_LOCK_IN[i];
            assign raw[i].sel = REGISTER_SELECT_LINES_IN[i];
            assign raw[i].data = HOST_DATA_IN[i];

            // A pin change is taken only once the last two stages agree
            always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    sync1[i] <= '0;
                    sync2[i] <= '0;
                    sync3[i] <= '0;
                    host[i] <= '0;
                    host_prev[i] <= '0;
                end else begin
                    sync1[i] <= raw[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                    if (sync2[i] == sync3[i]) begin
                        host[i] <= sync3[i];
                    end
                    host_prev[i] <= host[i];
                end
            end

            // Same decode at both ports; peer means the other index
            assign req[i] = host[i].cs && (host[i].sel == mbx_pkg::SEL_RAM_ACCESS_AUTOINC
                || host[i].sel == mbx_pkg::SEL_RAM_ACCESS_PLAIN);
            assign req_prev[i] = host_prev[i].cs && (host_prev[i].sel == mbx_pkg::SEL_RAM_ACCESS_AUTOINC
                || host_prev[i].sel == mbx_pkg::SEL_RAM_ACCESS_PLAIN);
            assign req_end[i] = req_prev[i] && !req[i];
            // Writes land on the rising edge of the write strobe
            assign wr_commit[i] = host_prev[i].cs && host_prev[i].we && !host[i].we;
            assign wr_data[i] = host_prev[i].data;
            assign rd_on[i] = host[i].cs && host[i].oe;
            assign rd_end[i] = host_prev[i].cs && host_prev[i].oe && !rd_on[i];
            assign lock_req[i] = cfg[i][mbx_pkg::CFG_SOFT_LOCK_REQUEST] | host[i].lock;
            assign lock_mine[i] = lock_owner == (i == 0 ? mbx_pkg::LOCK_BY_A : mbx_pkg::LOCK_BY_B);

            // Strobe decodes use the select that stood with the strobe, so a host that
            // moves its select right after the write still lands in the intended register
            assign note_wr[i] = wr_commit[i] && host_prev[i].sel == mbx_pkg::SEL_OUTGOING_NOTE;
            assign cfg_wr[i] = wr_commit[i] && host_prev[i].sel == mbx_pkg::SEL_PORT_CONFIGURATION;
            assign own_ptr_wr[i] = wr_commit[i] && host_prev[i].sel == mbx_pkg::SEL_OWN_RAM_POINTER;
            assign peer_ptr_wr[i] = wr_commit[i] && host_prev[i].sel == mbx_pkg::SEL_PEER_RAM_POINTER;
            assign note_taken[i] = rd_end[i] && host_prev[i].sel == mbx_pkg::SEL_INCOMING_NOTE;
            assign inc_done[i] = req_end[i] && grant[i] && host_prev[i].sel == mbx_pkg::SEL_RAM_ACCESS_AUTOINC;
            assign ram_wr[i] = wr_commit[i] && grant[i] && req_prev[i];

            assign cond[i] = (8'(note_flag[i]) << mbx_pkg::COND_INCOMING_NOTE_FLAG)
                | (8'(free_flag[i]) << mbx_pkg::COND_OUTGOING_FREE_FLAG)
                | (8'(lock_ack[i]) << mbx_pkg::COND_LOCK_ACKNOWLEDGE_FLAG);

            // Data locations pass RAM bytes straight through, only under a grant
            assign ram_rd[i] = grant[i] ? ram[ptr[i]] : mbx_pkg::IDLE_READ;
            assign view[i][mbx_pkg::SEL_RAM_ACCESS_AUTOINC] = ram_rd[i];
            assign view[i][mbx_pkg::SEL_RAM_ACCESS_PLAIN] = ram_rd[i];
            // Non-data registers are not gated by the grant; only the condition's lock acknowledge bit follows arbitration
            assign view[i][mbx_pkg::SEL_INCOMING_NOTE] = note[O];
            assign view[i][mbx_pkg::SEL_OUTGOING_NOTE] = note[i];
            assign view[i][mbx_pkg::SEL_PORT_CONFIGURATION] = cfg[i];
            assign view[i][mbx_pkg::SEL_OWN_RAM_POINTER] = ptr[i];
            assign view[i][mbx_pkg::SEL_PORT_CONDITION] = cond[i];
            assign view[i][mbx_pkg::SEL_PEER_RAM_POINTER] = ptr[O];
            assign read_value[i] = view[i][host[i].sel];

            // Own write beats peer write; increment only after a granted auto-inc cycle ends
            assign next_ptr[i] = own_ptr_wr[i] ? wr_data[i]
                : peer_ptr_wr[O] ? wr_data[O]
                : inc_done[i] ? ptr[i] + mbx_pkg::PTR_STEP
                : ptr[i];

            always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    ptr[i] <= mbx_pkg::PTR_RESET;
                    note[i] <= mbx_pkg::NOTE_RESET;
                    cfg[i] <= mbx_pkg::CFG_RESET;
                    note_flag[i] <= 1'b0;
                    free_flag[i] <= 1'b1;
                    lock_ack[i] <= 1'b0;
                end else begin
                    ptr[i] <= next_ptr[i];
                    // The note changes only at the strobe edge, so a read racing it sees the old byte
                    if (note_wr[i]) begin
                        note[i] <= wr_data[i];
                    end
                    if (cfg_wr[i]) begin
                        cfg[i] <= wr_data[i];
                    end
                    // Set wins over clear in the same cycle
                    note_flag[i] <= note_wr[O] || (note_flag[i] && !note_taken[i]);
                    free_flag[i] <= note_taken[O] || (free_flag[i] && !note_wr[i]);
                    // Acknowledge once the peer has left the RAM; drops with the soft bit
                    lock_ack[i] <= cfg[i][mbx_pkg::CFG_SOFT_LOCK_REQUEST] && !grant[O] && lock_mine[i];
                end
            end

            // Wait goes low on the first sampled cycle of a data access, and rises when the access ends or on a
            // sampling-clock rise after a grant was seen while that clock was high
            always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    ready[i] <= 1'b1;
                    grant_seen[i] <= 1'b0;
                end else if (!req[i]) begin
                    ready[i] <= 1'b1;
                    grant_seen[i] <= 1'b0;
                end else if (!req_prev[i]) begin
                    ready[i] <= 1'b0;
                    grant_seen[i] <= 1'b0;
                end else begin
                    if (wclk_rise && grant_seen[i]) begin
                        ready[i] <= 1'b1;
                    end
                    if (wclk && grant[i]) begin
                        grant_seen[i] <= 1'b1;
                    end
                end
            end

            // Pins are registered so hosts see clean levels, at the cost of one cycle of latency
            always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    HOST_DATA_OUT[i] <= mbx_pkg::IDLE_READ;
                    HOST_DATA_OE_OUT[i] <= 1'b0;
                    HOST_READY_OUT[i] <= 1'b1;
                end else begin
                    HOST_DATA_OUT[i] <= rd_on[i] ? read_value[i] : mbx_pkg::IDLE_READ;
                    HOST_DATA_OE_OUT[i] <= rd_on[i];
                    HOST_READY_OUT[i] <= ready[i] && !(req[i] && !req_prev[i]);
                end
            end
        end
    endgenerate

    // ************************************************************
    // Wait sampling clock
    // ************************************************************
    // Only the filtered level is used, so a glitch on this pin cannot release wait early
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            wclk_s1 <= 1'b0;
            wclk_s2 <= 1'b0;
            wclk_s3 <= 1'b0;
            wclk <= 1'b0;
            wclk_prev <= 1'b0;
        end else begin
            wclk_s1 <= WAIT_SYNC_CLOCK_IN;
            wclk_s2 <= wclk_s1;
            wclk_s3 <= wclk_s2;
            if (wclk_s2 == wclk_s3) begin
                wclk <= wclk_s3;
            end
            wclk_prev <= wclk;
        end
    end
    assign wclk_rise = wclk && !wclk_prev;

    // ************************************************************
    // Arbitration
    // ************************************************************
    // The free-running LFSR stands in for the metastable latch settling either way
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            lfsr <= mbx_pkg::LFSR_SEED;
        end else begin
            lfsr <= {1'b0, lfsr[7:1]} ^ (lfsr[0] ? mbx_pkg::LFSR_TAPS : 8'h00);
        end
    end

    // A fresh peer lock request blocks as well, before the owner register catches up
    assign lock_block[0] = lock_mine[1] || (lock_owner == mbx_pkg::LOCK_NONE && lock_req[1]);
    assign lock_block[1] = lock_mine[0] || (lock_owner == mbx_pkg::LOCK_NONE && lock_req[0]);
    // A port may rise only with the peer idle and not holding the lockout
    assign can_win[0] = req[0] && !grant[1] && !lock_block[0];
    assign can_win[1] = req[1] && !grant[0] && !lock_block[1];
    assign tie = can_win[0] && can_win[1];
    // Grants are registered; lfsr[0] settles a tie in the same cycle, so the winner rises as for a lone request
    assign next_grant[0] = req[0] && (grant[0] || (can_win[0] && !(tie && lfsr[0])));
    assign next_grant[1] = req[1] && (grant[1] || (can_win[1] && !(tie && !lfsr[0])));

    // Earlier lockout prevails; a tie is settled by the LFSR
    always_comb begin
        next_lock_owner = lock_owner;
        case (lock_owner)
            mbx_pkg::LOCK_NONE: begin
                if (lock_req[0] && lock_req[1]) begin
                    next_lock_owner = lfsr[1] ? mbx_pkg::LOCK_BY_A : mbx_pkg::LOCK_BY_B;
                end else if (lock_req[0]) begin
                    next_lock_owner = mbx_pkg::LOCK_BY_A;
                end else if (lock_req[1]) begin
                    next_lock_owner = mbx_pkg::LOCK_BY_B;
                end
            end
            mbx_pkg::LOCK_BY_A: begin
                if (!lock_req[0]) begin
                    next_lock_owner = mbx_pkg::LOCK_NONE;
                end
            end
            mbx_pkg::LOCK_BY_B: begin
                if (!lock_req[1]) begin
                    next_lock_owner = mbx_pkg::LOCK_NONE;
                end
            end
            default: begin
                next_lock_owner = mbx_pkg::LOCK_NONE;
            end
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            grant <= 2'h0;
            lock_owner <= mbx_pkg::LOCK_NONE;
            PORT_RAM_GRANT_OUT <= 2'h0;
        end else begin
            grant <= next_grant;
            lock_owner <= next_lock_owner;
            PORT_RAM_GRANT_OUT <= next_grant;
        end
    end

    // ************************************************************
    // Shared RAM
    // ************************************************************
    // No reset on the array: contents are undefined until a host writes them
    // Only the granted port writes, at its own pointer
    always_ff @(posedge MCLK_IN) begin
        for (int p = 0; p < mbx_pkg::NUM_PORTS; p++) begin
            if (ram_wr[p]) begin
                ram[ptr[p]] <= wr_data[p];
            end
        end
    end

endmodule

// *** tb/mbx_checker.sv ***
// Concurrent checks on the mailbox top-level pins.
// Assumes the single core clock and the asynchronous active-low reset of the top.
`timescale 1ns/1ps
module mbx_checker (
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [1:0] HOST_CS_N_IN,
    input wire logic [1:0] HOST_LOCK_IN,
    input wire logic [1:0][2:0] REGISTER_SELECT_LINES_IN,
    input wire logic [1:0] HOST_DATA_OE_OUT,
    input wire logic [1:0] HOST_READY_OUT,
    input wire logic [1:0] PORT_RAM_GRANT_OUT
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    // ************************************************************
    // Arbitration and wait handshake
    // ************************************************************
    sequence s_req_a;
        $fell(HOST_CS_N_IN[0]) && REGISTER_SELECT_LINES_IN[0][2:1] == 2'b00;
    endsequence
    sequence s_drop_a;
        $rose(HOST_CS_N_IN[0]) && PORT_RAM_GRANT_OUT[0];
    endsequence
    property p_excl;
        !(PORT_RAM_GRANT_OUT[0] && PORT_RAM_GRANT_OUT[1]);
    endproperty
    a_excl: assert property (p_excl) else $error("both grants high");
    // Pins must have been stable through the input filter before a grant
    property p_gnt_req_a;
        $rose(PORT_RAM_GRANT_OUT[0]) |-> !$past(HOST_CS_N_IN[0], 3)
            && $past(REGISTER_SELECT_LINES_IN[0][2:1], 3) == 2'b00;
    endproperty
    a_gnt_req_a: assert property (p_gnt_req_a) else $error("grant a without data request");
    property p_gnt_req_b;
        $rose(PORT_RAM_GRANT_OUT[1]) |-> !$past(HOST_CS_N_IN[1], 3)
            && $past(REGISTER_SELECT_LINES_IN[1][2:1], 3) == 2'b00;
    endproperty
    a_gnt_req_b: assert property (p_gnt_req_b) else $error("grant b without data request");
    property p_rdy_fall_a;
        s_req_a |-> ##[1:8] !HOST_READY_OUT[0];
    endproperty
    a_rdy_fall_a: assert property (p_rdy_fall_a) else $error("wait not raised on data access");
    property p_rdy_rise_a;
        $rose(HOST_READY_OUT[0]) |-> $past(PORT_RAM_GRANT_OUT[0]);
    endproperty
    a_rdy_rise_a: assert property (p_rdy_rise_a) else $error("ready rose without grant");
    property p_gnt_drop_a;
        s_drop_a |-> ##[1:8] !PORT_RAM_GRANT_OUT[0];
    endproperty
    a_gnt_drop_a: assert property (p_gnt_drop_a) else $error("grant a held after release");
    property p_idle_a;
        HOST_CS_N_IN[0] [*6] |-> !HOST_DATA_OE_OUT[0] && HOST_READY_OUT[0];
    endproperty
    a_idle_a: assert property (p_idle_a) else $error("port a busy while deselected");
    property p_lock_b;
        HOST_LOCK_IN[1] [*8] |-> !$rose(PORT_RAM_GRANT_OUT[0]);
    endproperty
    a_lock_b: assert property (p_lock_b) else $error("grant a during lockout by b");
endmodule
bind mbx_top mbx_checker i_mbx_checker (.MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN), .HOST_CS_N_IN(HOST_CS_N_IN),
    .HOST_LOCK_IN(HOST_LOCK_IN), .REGISTER_SELECT_LINES_IN(REGISTER_SELECT_LINES_IN),
    .HOST_DATA_OE_OUT(HOST_DATA_OE_OUT), .HOST_READY_OUT(HOST_READY_OUT), .PORT_RAM_GRANT_OUT(PORT_RAM_GRANT_OUT));

// *** tb/mbx_host.sv ***
// Behavioural host processor on one mailbox port.
// Assumes the core clock; pins change just after its falling edge.
`timescale 1ns/1ps
module mbx_host (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic data_oe_in,
    input wire logic ready_in,
    output mbx_pkg::mbx_host_t bus_out
);
    logic hung;
    initial begin
        hung = 1'b0;
        bus_out = '{cs: 1'b1, we: 1'b1, oe: 1'b1, lock: 1'b0, sel: 3'h0, data: 8'h00};
    end
    // Rides out arbitration on the wait signal instead of coordinating
    task automatic wait_go(input logic need_oe);
        int n;
        n = 0;
        while (n < 300 && !(n >= 6 && ready_in === 1'b1 && (data_oe_in === 1'b1 || !need_oe))) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 300) hung = 1'b1;
    endtask
    // Released data lines show the inverse so stale values cannot pass
    task automatic idle();
        bus_out.cs = 1'b1;
        bus_out.oe = 1'b1;
        bus_out.data = ~bus_out.data;
        repeat (6) @(negedge clk_in);
    endtask
    task automatic wr(input mbx_pkg::mbx_sel_t s, input logic [7:0] d);
        @(negedge clk_in);
        bus_out.sel = s;
        bus_out.data = d;
        bus_out.cs = 1'b0;
        bus_out.we = 1'b0;
        wait_go(1'b0);
        bus_out.we = 1'b1;
        repeat (6) @(negedge clk_in);
        idle();
    endtask
    task automatic rd(input mbx_pkg::mbx_sel_t s, input int hold, output logic [7:0] q);
        @(negedge clk_in);
        bus_out.sel = s;
        bus_out.cs = 1'b0;
        bus_out.oe = 1'b0;
        wait_go(1'b1);
        q = rdata_in;
        repeat (hold) @(negedge clk_in);
        idle();
    endtask
    task automatic set_lock(input logic v);
        @(negedge clk_in);
        bus_out.lock = v;
    endtask
endmodule

// *** tb/mbx_top_tb.sv ***
// Self-checking bench: two host models exercise both mailbox ports.
// Assumes the package, the design top, the checker and the host model compile first.
`timescale 1ns/1ps
module mbx_top_tb;
    logic mclk, arst_n, wclk;
    mbx_pkg::mbx_host_t bus_a, bus_b;
    logic [1:0][7:0] rdata;
    logic [1:0] doe, rdy, gnt;
    int n_fail, num_checks;
    logic [7:0] q, qb;
    logic [7:0] rst_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    initial wclk = 1'b0;
    always #50 wclk = ~wclk;
    mbx_top i_mbx_top (.MCLK_IN(mclk), .ARST_N_IN(arst_n), .WAIT_SYNC_CLOCK_IN(wclk),
        .HOST_CS_N_IN({bus_b.cs, bus_a.cs}), .HOST_WE_N_IN({bus_b.we, bus_a.we}), .HOST_OE_N_IN({bus_b.oe, bus_a.oe}),
        .HOST_LOCK_IN({bus_b.lock, bus_a.lock}), .REGISTER_SELECT_LINES_IN({bus_b.sel, bus_a.sel}),
        .HOST_DATA_IN({bus_b.data, bus_a.data}), .HOST_DATA_OUT(rdata), .HOST_DATA_OE_OUT(doe),
        .HOST_READY_OUT(rdy), .PORT_RAM_GRANT_OUT(gnt));
    mbx_host i_host_a (.clk_in(mclk), .rdata_in(rdata[0]), .data_oe_in(doe[0]), .ready_in(rdy[0]), .bus_out(bus_a));
    mbx_host i_host_b (.clk_in(mclk), .rdata_in(rdata[1]), .data_oe_in(doe[1]), .ready_in(rdy[1]), .bus_out(bus_b));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        $display("unexpected at %0t: run hung", $time);
        report_and_stop();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        arst_n = 1'b0;
        n_fail = 0;
        num_checks = 0;
        repeat (10) @(negedge mclk);
        arst_n = 1'b1;
        repeat (2) @(negedge mclk);
        foreach (rst_exp[i]) begin
            i_host_a.rd(mbx_pkg::mbx_sel_t'(i + 2), 0, q);
            chk(q, rst_exp[i]);
            i_host_b.rd(mbx_pkg::mbx_sel_t'(i + 2), 0, q);
            chk(q, rst_exp[i]);
        end
        i_host_a.wr(3'h5, 8'hfe);
        // Peer pointer read only once the owner's write has finished
        i_host_b.rd(3'h7, 0, q);
        chk(q, 8'hfe);
        i_host_a.wr(3'h0, 8'h11);
        i_host_a.wr(3'h0, 8'h22);
        i_host_a.rd(3'h5, 0, q);
        chk(q, 8'h00);
        // Peer pointer written only while port A is idle
        i_host_b.wr(3'h7, 8'hff);
        i_host_a.rd(3'h1, 0, q);
        chk(q, 8'h22);
        i_host_b.wr(3'h5, 8'hfe);
        i_host_b.rd(3'h1, 0, q);
        chk(q, 8'h11);
        i_host_b.rd(3'h0, 0, q);
        chk(q, 8'h11);
        i_host_a.rd(3'h7, 0, q);
        chk(q, 8'hff);
        i_host_a.rd(3'h5, 0, q);
        chk(q, 8'hff);
        i_host_a.wr(3'h3, 8'h5a);
        i_host_a.wr(3'h2, 8'hff);
        i_host_b.rd(3'h6, 0, q);
        chk(q, 8'h03);
        i_host_a.rd(3'h6, 0, q);
        chk(q, 8'h00);
        i_host_b.rd(3'h2, 0, q);
        chk(q, 8'h5a);
        i_host_b.rd(3'h6, 0, q);
        chk(q, 8'h02);
        i_host_a.rd(3'h6, 0, q);
        chk(q, 8'h02);
        i_host_a.rd(3'h2, 0, q);
        chk(q, 8'h00);
        // Read of a note while its owner is mid-write sees the old byte
        fork
            i_host_a.wr(3'h3, 8'hc3);
            i_host_b.rd(3'h2, 0, qb);
        join
        chk(qb, 8'h5a);
        i_host_b.rd(3'h2, 0, q);
        chk(q, 8'hc3);
        i_host_a.wr(3'h1, 8'h77);
        fork
            i_host_a.rd(3'h1, 40, q);
            begin
                repeat (8) @(negedge mclk);
                i_host_b.rd(3'h6, 0, qb);
                chk(qb, 8'h02);
                fork
                    i_host_b.rd(3'h1, 0, qb);
                    begin
                        repeat (12) @(negedge mclk);
                        chk({4'h0, rdy, gnt}, 8'h05);
                    end
                join
                chk(qb, 8'h77);
            end
        join
        chk(q, 8'h77);
        fork
            i_host_a.rd(3'h1, 0, q);
            i_host_b.rd(3'h1, 0, qb);
        join
        chk(q, 8'h77);
        chk(qb, 8'h77);
        i_host_b.set_lock(1'b1);
        repeat (6) @(negedge mclk);
        fork
            i_host_a.rd(3'h1, 0, q);
            begin
                repeat (30) @(negedge mclk);
                chk({6'h0, rdy[0], gnt[0]}, 8'h00);
                i_host_b.set_lock(1'b0);
            end
        join
        chk(q, 8'h77);
        i_host_a.wr(3'h4, 8'h01);
        i_host_a.rd(3'h6, 0, q);
        chk(q, 8'h06);
        i_host_a.wr(3'h4, 8'h00);
        i_host_a.rd(3'h6, 0, q);
        chk(q, 8'h02);
        chk({6'h0, i_host_a.hung, i_host_b.hung}, 8'h00);
        report_and_stop();
    end
endmodule
